// ---- common/adc_seq_pkg.sv ----
// constants, register map and timing of the conversion sequencer
// What this block does
// R1: channel select is the fixed channel, or the top channel of each scan round
// R2: channel select writes apply after the conversion, or after the scan round
// R3: busy is set on start and held while converting, cleared when idle
// R4: status sample flag is high exactly during each sampling phase; the o_sample pin follows one cycle later
// R5: start samples, holds, converts, stores result with channel tag, raises completion flag
// R6: hardware clears start after fixed single conversion, or after channel 0 in scan single
// R7: continuous modes never clear start by hardware
// R8: software stop in scan modes finishes the round through channel 0
// R9: software stop in fixed modes finishes the conversion, then stops and clears busy
// R10: clearing then setting start aborts and restarts with current settings
// R11: mode codes 00 fixed single, 01 fixed continuous, 10 scan single, 11 scan continuous
// R12: a mode change is evaluated only after the running conversion
// R13: resolution bit zero gives 10-bit result, one gives faster 8-bit result
// R14: conversion results go to the primary result register; the alternate is written by software only
// R15: device loads channel tag bits 15:12 of primary result, never the alternate
// R16: result alignment follows compatibility or enhanced placement and resolution
// R17: result bits unused by the placement read as zero
// R18: fixed single sets completion flag, stops, clears busy and start
// R19: fixed continuous restarts the channel after each conversion, flag each time
// R20: scan modes flag each conversion and step down to channel 0
// R21: scan continuous restarts the round from channel select after channel 0
// R22: conversion core is a request/done handshake, shorter latency for 8-bit
package adc_seq_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [31:0] CTRL_OFFS = 32'h0000_0000;
  localparam logic [31:0] CFG_OFFS  = 32'h0000_0004;
  localparam logic [31:0] STAT_OFFS = 32'h0000_0008;
  localparam logic [31:0] INJ_OFFS  = 32'h0000_f0a0;
  localparam logic [31:0] RES_OFFS  = 32'h0000_fea0;

  // ==========================================================
  // field positions
  localparam int CH_LSB      = 0;
  localparam int CH_W        = 4;
  localparam int MODE_LSB    = 5;
  localparam int START_BIT   = 7;
  localparam int BUSY_BIT    = 8;
  localparam int RES8_BIT    = 0;
  localparam int ENH_BIT     = 1;
  localparam int SAMPLE_BIT  = 0;
  localparam int DONE_BIT    = 1;
  localparam int TAG_LSB     = 12;
  localparam int VAL_W       = 12;
  localparam int CODE_W      = 10;

  // ==========================================================
  // reset values
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [15:0] INJ_RST    = 16'h0000;
  localparam logic [3:0]  CH_RST     = 4'h0;
  localparam logic [1:0]  MODE_RST   = 2'h0;

  // ==========================================================
  // conversion modes
  localparam logic [1:0] MODE_FIX_SINGLE  = 2'b00;
  localparam logic [1:0] MODE_FIX_CONT    = 2'b01;
  localparam logic [1:0] MODE_SCAN_SINGLE = 2'b10;
  localparam logic [1:0] MODE_SCAN_CONT   = 2'b11;

  // ==========================================================
  // timing of the conversion core model
  localparam int CLK_MHZ        = 20;
  localparam int SAMPLE_TIME_NS = 500;
  localparam int CONV10_TIME_NS = 2000;
  localparam int CONV8_TIME_NS  = 1600;
  localparam int SAMPLE_CYC     = (SAMPLE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV10_CYC     = (CONV10_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV8_CYC      = (CONV8_TIME_NS * CLK_MHZ + 999) / 1000;

endpackage : adc_seq_pkg

// ---- core/adc_core_model.sv ----
// request/done model of the sample-and-convert core
module adc_core_model #(
  parameter int SAMPLE_CYCLES = adc_seq_pkg::SAMPLE_CYC,
  parameter int CONV10_CYCLES = adc_seq_pkg::CONV10_CYC,
  parameter int CONV8_CYCLES  = adc_seq_pkg::CONV8_CYC
) (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_req,
  input  wire logic                          i_abort,
  input  wire logic                          i_res8,
  input  wire logic [adc_seq_pkg::CODE_W-1:0] i_code,
  output logic                               o_sample,
  output logic                               o_done,
  output logic [adc_seq_pkg::CODE_W-1:0]      o_code
);

  if (SAMPLE_CYCLES < 1 || CONV8_CYCLES < 1 || CONV8_CYCLES > CONV10_CYCLES || CONV10_CYCLES > 65535) begin : g_bad
    $error("adc_core_model: latency parameters out of range");
  end

  typedef enum logic [1:0] {PH_IDLE, PH_SAMPLE, PH_CONVERT} phase_t;

  phase_t      phase_r;
  logic [15:0] cnt_r;
  logic [15:0] conv_len;

  // ==========================================================
  // latency select
  assign conv_len = i_res8 ? 16'(CONV8_CYCLES) : 16'(CONV10_CYCLES); // see R22, R13

  // ==========================================================
  // phase sequencer
  always_ff @(posedge i_sys_clk) begin
    o_done <= 1'b0;
    if (i_rst || i_abort) begin
      phase_r  <= PH_IDLE;
      cnt_r    <= 16'h0000;
      o_sample <= 1'b0;
      if (i_rst) begin
        o_code <= '0;
      end
    end else begin
      unique case (phase_r)
        PH_IDLE: begin
          if (i_req) begin
            phase_r  <= PH_SAMPLE;
            cnt_r    <= 16'(SAMPLE_CYCLES - 1);
            o_sample <= 1'b1; // see R4
          end
        end
        PH_SAMPLE: begin
          if (cnt_r == 16'h0000) begin
            // level is held from here on while converting
            o_code   <= i_code; // see R5
            o_sample <= 1'b0;
            phase_r  <= PH_CONVERT;
            cnt_r    <= conv_len - 16'h0001;
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        PH_CONVERT: begin
          if (cnt_r == 16'h0000) begin
            o_done  <= 1'b1; // see R22
            phase_r <= PH_IDLE;
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        default: begin
          phase_r <= PH_IDLE;
        end
      endcase
    end
  end

endmodule : adc_core_model

// ---- core/adc_conversion_sequencer.sv ----
// converter sequencer with apb register file
//
// The APB register port is this design's own decision.
module adc_conversion_sequencer #(
  parameter int SAMPLE_CYCLES = adc_seq_pkg::SAMPLE_CYC,
  parameter int CONV10_CYCLES = adc_seq_pkg::CONV10_CYC,
  parameter int CONV8_CYCLES  = adc_seq_pkg::CONV8_CYC
) (
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_rst,
  input  wire logic                           i_psel,
  input  wire logic                           i_penable,
  input  wire logic                           i_pwrite,
  input  wire logic [31:0]                    i_paddr,
  input  wire logic [31:0]                    i_pwdata,
  output logic                                o_pready,
  output logic [31:0]                         o_prdata,
  output logic                                o_pslverr,
  input  wire logic [adc_seq_pkg::CODE_W-1:0] i_analog_code,
  output logic [adc_seq_pkg::CH_W-1:0]        o_mux_channel,
  output logic                                o_busy,
  output logic                                o_sample,
  output logic                                o_completion_irq_flag
);

  typedef enum logic [1:0] {ST_IDLE, ST_LAUNCH, ST_WAIT} seq_state_t;

  localparam int CHW = adc_seq_pkg::CH_W;
  localparam int CW  = adc_seq_pkg::CODE_W;

  // the level passes the mux register and two sync flops before the core may hold it
  if (SAMPLE_CYCLES < 3) begin : g_bad_sample
    $error("adc_conversion_sequencer: sample phase shorter than the input path");
  end

  // ==========================================================
  // declarations
  logic [CW-1:0]   code_meta_r;
  logic [CW-1:0]   code_sync_r;
  logic            pready_r;
  logic [31:0]     prdata_r;
  logic            pslverr_r;
  logic [CHW-1:0]  channel_select_r;
  logic [1:0]      conversion_mode_field_r;
  logic            start_stop_bit_r;
  logic            start_stop_bit_nxt;
  logic            res8_r;
  logic            enhanced_r;
  logic            busy_flag_r;
  logic            completion_irq_flag_r;
  logic            completion_irq_flag_nxt;
  logic [15:0]     conversion_result_r;
  logic [15:0]     conversion_result_nxt;
  logic [15:0]     injected_result_r;
  seq_state_t      state_r;
  seq_state_t      state_nxt;
  logic [CHW-1:0]  cur_ch_r;
  logic [CHW-1:0]  cur_ch_nxt;
  logic            load_sel_r;
  logic            load_sel_nxt;
  logic            res_act_r;
  logic            core_sample;
  logic            core_done;
  logic [CW-1:0]   core_code;
  logic            sample_out_r;

  // ==========================================================
  // analog code input synchroniser
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      code_meta_r <= '0;
      code_sync_r <= '0;
    end else begin
      code_meta_r <= i_analog_code;
      code_sync_r <= code_meta_r;
    end
  end

  // ==========================================================
  // apb decode
  wire setup_phase = i_psel & ~i_penable;
  wire access_done = i_psel & i_penable & pready_r;
  wire wr_en       = access_done & i_pwrite;
  wire hit_ctrl    = (i_paddr == adc_seq_pkg::CTRL_OFFS);
  wire hit_cfg     = (i_paddr == adc_seq_pkg::CFG_OFFS);
  wire hit_stat    = (i_paddr == adc_seq_pkg::STAT_OFFS);
  wire hit_inj     = (i_paddr == adc_seq_pkg::INJ_OFFS);
  wire hit_res     = (i_paddr == adc_seq_pkg::RES_OFFS);
  wire mapped      = hit_ctrl | hit_cfg | hit_stat | hit_inj | hit_res;
  wire wr_ctrl     = wr_en & hit_ctrl;
  wire wr_cfg      = wr_en & hit_cfg;
  wire wr_stat     = wr_en & hit_stat;
  wire wr_inj      = wr_en & hit_inj;
  wire wr_res      = wr_en & hit_res;

  wire [31:0] rd_ctrl = {23'h000000, busy_flag_r, start_stop_bit_r, conversion_mode_field_r,
                         1'b0, channel_select_r};
  wire [31:0] rd_cfg  = {30'h00000000, enhanced_r, res8_r};
  wire [31:0] rd_stat = {30'h00000000, completion_irq_flag_r, core_sample};
  wire [31:0] rd_data = hit_ctrl ? rd_ctrl :
                        hit_cfg  ? rd_cfg  :
                        hit_stat ? rd_stat :
                        hit_inj  ? {16'h0000, injected_result_r} :
                        hit_res  ? {16'h0000, conversion_result_r} : 32'h0000_0000;

  // one wait-free access: answer is prepared during the setup cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup_phase;
      pslverr_r <= setup_phase & ~mapped;
      if (setup_phase) begin
        prdata_r <= i_pwrite ? 32'h0000_0000 : rd_data;
      end
    end
  end

  // ==========================================================
  // start control and sequencing decisions
  wire sw_start_wr = wr_ctrl & i_pwdata[adc_seq_pkg::START_BIT];
  wire core_busy   = (state_r != ST_IDLE);
  wire done_evt    = (state_r == ST_WAIT) & core_done;
  wire scan_mode   = conversion_mode_field_r[1]; // see R11
  wire round_left  = scan_mode & (cur_ch_r != '0);
  wire fix_again   = (conversion_mode_field_r == adc_seq_pkg::MODE_FIX_CONT) & start_stop_bit_r;
  wire scan_again  = (conversion_mode_field_r == adc_seq_pkg::MODE_SCAN_CONT) & start_stop_bit_r;
  wire single_mode = (conversion_mode_field_r == adc_seq_pkg::MODE_FIX_SINGLE) |
                     (conversion_mode_field_r == adc_seq_pkg::MODE_SCAN_SINGLE);
  // only single modes end by clearing start; continuous modes leave it alone
  wire stop_evt    = done_evt & ~round_left & ~fix_again & ~scan_again; // see R9, R8
  wire hw_clear    = stop_evt & single_mode; // see R6, R7, R18
  // a 0->1 toggle of start; a toggle that meets the hardware clear still counts
  wire start_req   = sw_start_wr & (~start_stop_bit_r | hw_clear);
  wire restart     = start_req & core_busy; // see R10
  wire core_req    = (state_r == ST_LAUNCH);
  wire [CHW-1:0] launch_ch = load_sel_r ? channel_select_r : cur_ch_r; // see R1, R2

  always_comb begin
    state_nxt    = state_r;
    cur_ch_nxt   = cur_ch_r;
    load_sel_nxt = load_sel_r;
    if (start_req) begin
      state_nxt    = ST_LAUNCH; // see R10
      load_sel_nxt = 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          state_nxt = ST_IDLE;
        end
        ST_LAUNCH: begin
          state_nxt    = ST_WAIT;
          cur_ch_nxt   = launch_ch;
          load_sel_nxt = 1'b0;
        end
        ST_WAIT: begin
          if (done_evt) begin
            // mode is read here, only once the conversion has ended
            if (round_left) begin
              state_nxt    = ST_LAUNCH; // see R20, R12
              cur_ch_nxt   = cur_ch_r - 4'h1;
              load_sel_nxt = 1'b0;
            end else if (fix_again || scan_again) begin
              state_nxt    = ST_LAUNCH; // see R19, R21
              load_sel_nxt = 1'b1;
            end else begin
              state_nxt = ST_IDLE; // see R18, R9
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    start_stop_bit_nxt = start_stop_bit_r;
    if (wr_ctrl) begin
      // software write wins over the hardware clear of the same cycle
      start_stop_bit_nxt = i_pwdata[adc_seq_pkg::START_BIT];
    end else if (hw_clear) begin
      start_stop_bit_nxt = 1'b0; // see R6, R18
    end
  end

  // ==========================================================
  // result placement
  wire [7:0]    res8_val  = core_code[CW-1:2];
  wire [CW-1:0] res10_val = core_code;
  wire [11:0]   aligned   = enhanced_r ?
                            (res_act_r ? {res8_val, 4'h0} : {res10_val, 2'b00}) :
                            (res_act_r ? {2'b00, res8_val, 2'b00} : {2'b00, res10_val}); // see R16, R17

  always_comb begin
    conversion_result_nxt   = conversion_result_r;
    completion_irq_flag_nxt = completion_irq_flag_r;
    if (wr_res) begin
      conversion_result_nxt = i_pwdata[15:0];
    end
    if (wr_stat && i_pwdata[adc_seq_pkg::DONE_BIT]) begin
      completion_irq_flag_nxt = 1'b0;
    end
    if (done_evt && !restart) begin
      conversion_result_nxt   = {cur_ch_r, aligned}; // see R5, R14, R15
      completion_irq_flag_nxt = 1'b1; // see R5, R19, R20
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      channel_select_r        <= adc_seq_pkg::CH_RST;
      conversion_mode_field_r <= adc_seq_pkg::MODE_RST;
      res8_r                  <= 1'b0;
      enhanced_r              <= 1'b0;
      injected_result_r       <= adc_seq_pkg::INJ_RST;
    end else begin
      if (wr_ctrl) begin
        channel_select_r        <= i_pwdata[adc_seq_pkg::CH_LSB +: CHW];
        conversion_mode_field_r <= i_pwdata[adc_seq_pkg::MODE_LSB +: 2];
      end
      if (wr_cfg) begin
        res8_r     <= i_pwdata[adc_seq_pkg::RES8_BIT]; // see R13
        enhanced_r <= i_pwdata[adc_seq_pkg::ENH_BIT];
      end
      if (wr_inj) begin
        // alternate register is software-owned; the sequencer never writes it
        injected_result_r <= i_pwdata[15:0]; // see R14, R15
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      start_stop_bit_r      <= 1'b0;
      completion_irq_flag_r <= 1'b0;
      conversion_result_r   <= adc_seq_pkg::RESULT_RST;
    end else begin
      start_stop_bit_r      <= start_stop_bit_nxt;
      completion_irq_flag_r <= completion_irq_flag_nxt;
      conversion_result_r   <= conversion_result_nxt;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_r     <= ST_IDLE;
      cur_ch_r    <= '0;
      load_sel_r  <= 1'b0;
      busy_flag_r <= 1'b0;
      res_act_r   <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cur_ch_r    <= cur_ch_nxt;
      load_sel_r  <= load_sel_nxt;
      busy_flag_r <= (state_nxt != ST_IDLE); // see R3
      if (core_req) begin
        res_act_r <= res8_r;
      end
    end
  end

  // ==========================================================
  // outputs
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_mux_channel <= '0;
      sample_out_r  <= 1'b0;
    end else begin
      sample_out_r <= core_sample; // see R4
      if (core_req) begin
        o_mux_channel <= launch_ch; // see R1
      end
    end
  end

  assign o_pready              = pready_r;
  assign o_prdata              = prdata_r;
  assign o_pslverr             = pslverr_r;
  assign o_busy                = busy_flag_r;
  assign o_sample              = sample_out_r;
  assign o_completion_irq_flag = completion_irq_flag_r;

  // ==========================================================
  // conversion core
  adc_core_model #(
    .SAMPLE_CYCLES (SAMPLE_CYCLES),
    .CONV10_CYCLES (CONV10_CYCLES),
    .CONV8_CYCLES  (CONV8_CYCLES)
  ) u_core (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_req     (core_req),
    .i_abort   (restart),
    .i_res8    (res_act_r), // latency follows the resolution latched at launch, see R13
    .i_code    (code_sync_r),
    .o_sample  (core_sample),
    .o_done    (core_done),
    .o_code    (core_code)
  );

endmodule : adc_conversion_sequencer

// ---- bench/adc_analog_front.sv ----
// behavioural analog multiplexer and level source in front of the converter
module adc_analog_front #(
  parameter int SETTLE_CYCLES = 0
) (
  input  wire logic                           i_sys_clk,
  input  wire logic [adc_seq_pkg::CH_W-1:0]   i_mux_channel,
  output logic      [adc_seq_pkg::CODE_W-1:0] o_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] ch_r;
  int         age_r;
  // each input carries its own level so a wrong channel shows in the result
  wire  [9:0] level = {i_mux_channel, 6'h2b};
  always @(posedge i_sys_clk) begin
    ch_r <= i_mux_channel;
    age_r <= (ch_r != i_mux_channel) ? 0 : age_r + 1;
  end
  // while the mux settles the level swings rather than holding the old input
  assign o_code = (age_r < SETTLE_CYCLES) ? ~level : level;
endmodule : adc_analog_front

// ---- bench/adc_seq_checker_props.sv ----
// port-level properties of the conversion sequencer
module adc_seq_checker #(
  parameter int SAMPLE_CYCLES = 2
) (
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [3:0]  o_mux_channel,
  input wire logic        o_busy,
  input wire logic        o_sample,
  input wire logic        o_completion_irq_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  int smp_len_r;
  wire acc = i_psel && i_penable && i_pwrite;
  wire ctrl_wr = acc && i_paddr == adc_seq_pkg::CTRL_OFFS;
  wire stat_clr = acc && i_paddr == adc_seq_pkg::STAT_OFFS && i_pwdata[1];
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // helper: length of the current sample phase
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !o_sample) smp_len_r <= 0;
    else smp_len_r <= smp_len_r + 1;
  end
  // ==========================================================
  // assertions
  chk_ready_next: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  chk_ready_access: assert property (o_pready |-> i_psel && i_penable)
    else $error("ready outside access");
  chk_busy_cause: assert property ($rose(o_busy) |-> $past(ctrl_wr && i_pwdata[7]))
    else $error("busy without start");
  chk_sample_busy: assert property (o_sample |-> o_busy)
    else $error("sample while idle");
  chk_sample_len: assert property ($fell(o_sample) |-> smp_len_r == SAMPLE_CYCLES)
    else $error("sample phase length wrong");
  chk_channel_held: assert property (o_sample && $past(o_sample) |-> $stable(o_mux_channel))
    else $error("channel moved while sampling");
  chk_flag_sticky: assert property (o_completion_irq_flag && !stat_clr |=> o_completion_irq_flag)
    else $error("completion flag dropped");
  chk_stop_flag: assert property ($fell(o_busy) |-> ##[0:2] o_completion_irq_flag)
    else $error("stopped without completion");
  cover property ($fell(o_busy));
  cover property ($rose(o_sample));
  cover property (o_pready && o_pslverr);
endmodule : adc_seq_checker

bind adc_conversion_sequencer adc_seq_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_adc_seq_checker (
  .i_sys_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready,
  .o_pslverr, .o_mux_channel, .o_busy, .o_sample, .o_completion_irq_flag);

// ---- bench/adc_conversion_sequencer_test.sv ----
// self-checking bench of the conversion sequencer
module adc_conversion_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] A_CTRL = adc_seq_pkg::CTRL_OFFS;
  localparam logic [31:0] A_CFG  = adc_seq_pkg::CFG_OFFS;
  localparam logic [31:0] A_STAT = adc_seq_pkg::STAT_OFFS;
  localparam logic [31:0] A_INJ  = adc_seq_pkg::INJ_OFFS;
  localparam logic [31:0] A_RES  = adc_seq_pkg::RES_OFFS;
  typedef struct {logic [3:0] ch; logic r8; logic enh; logic [31:0] res;} row_t;
  logic        i_sys_clk, i_rst, i_psel, i_penable, i_pwrite, err_v;
  logic        o_pready, o_pslverr, o_busy, o_sample, o_completion_irq_flag, smp_d;
  logic [31:0] i_paddr, i_pwdata, o_prdata, rd_v;
  logic [9:0]  code;
  logic [3:0]  o_mux_channel;
  logic [3:0]  seen_q[$];
  int          errors, check_count, cyc, lat[4];
  // level of a channel is {ch, 2b}; result placed per resolution and alignment
  row_t rows[4] = '{'{4'h3, 1'b0, 1'b0, 32'h30eb}, '{4'h9, 1'b1, 1'b0, 32'h9268},
                    '{4'hf, 1'b0, 1'b1, 32'hffac}, '{4'h0, 1'b1, 1'b1, 32'h00a0}};

  adc_conversion_sequencer #(.SAMPLE_CYCLES(3), .CONV10_CYCLES(12), .CONV8_CYCLES(6)) i_adc_conversion_sequencer (
    .i_sys_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata,
    .o_pslverr, .i_analog_code(code), .o_mux_channel, .o_busy, .o_sample, .o_completion_irq_flag);
  adc_analog_front i_adc_analog_front (.i_sys_clk, .i_mux_channel(o_mux_channel), .o_code(code));

  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  // ==========================================================
  // channel log at each sample start, and the hang limit
  always @(posedge i_sys_clk) begin
    smp_d <= o_sample;
    if (o_sample === 1'b1 && smp_d !== 1'b1) seen_q.push_back(o_mux_channel);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      wrap_up();
    end
  end
  // ==========================================================
  // tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do @(posedge i_sys_clk); while (o_pready !== 1'b1);
    rd_v = o_prdata;
    err_v = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, rd_v, exp);
  endtask : rd_chk
  task automatic wait_idle(output int n);
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_busy !== 1'b0);
  endtask : wait_idle
  task automatic wait_q(input int n);
    while (seen_q.size() < n) @(posedge i_sys_clk);
  endtask : wait_q
  function automatic logic [31:0] ctl(logic [3:0] ch, logic [1:0] m, logic st);
    return {24'h0, st, m, 1'b0, ch};
  endfunction : ctl
  function automatic logic [31:0] q_pack();
    logic [31:0] p;
    p = 32'h0;
    foreach (seen_q[i]) p = (p << 4) | {28'h0, seen_q[i]};
    return p;
  endfunction : q_pack
  task automatic wrap_up();
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // ==========================================================
  // main sequence
  initial begin
    i_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 32'h0;
    i_pwdata = 32'h0;
    repeat (5) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    foreach (rows[i]) begin
      wr(A_CFG, {30'h0, rows[i].enh, rows[i].r8});
      wr(A_CTRL, ctl(rows[i].ch, 2'b00, 1'b1));
      wait_idle(lat[i]);
      check("irq pin", {31'h0, o_completion_irq_flag}, 32'h1);
      rd_chk("result", A_RES, rows[i].res);
      rd_chk("control", A_CTRL, ctl(rows[i].ch, 2'b00, 1'b0));
      rd_chk("status", A_STAT, 32'h2);
      wr(A_STAT, 32'h2);
    end
    check("short 8-bit", {31'h0, lat[1] < lat[0]}, 32'h1);
    // reset values, read-only busy, unmapped access, software-only register
    i_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    foreach (rows[i]) rd_chk("reset value", i == 0 ? A_RES : i == 1 ? A_INJ : i == 2 ? A_CFG : A_STAT, 32'h0);
    wr(A_CTRL, 32'h100);
    rd_chk("busy read-only", A_CTRL, 32'h0);
    apb(1'b0, 32'h100, 32'h0);
    check("slverr", {31'h0, err_v}, 32'h1);
    wr(A_INJ, 32'h5a3c);
    // scan single from 3, 10-bit from here on
    seen_q.delete();
    wr(A_CTRL, ctl(4'h3, 2'b10, 1'b1));
    wait_idle(lat[0]);
    check("scan order", q_pack(), 32'h3210);
    rd_chk("scan stop", A_CTRL, ctl(4'h3, 2'b10, 1'b0));
    // scan continuous: channel change applies per round, stop finishes the round
    seen_q.delete();
    wr(A_CTRL, ctl(4'h2, 2'b11, 1'b1));
    wait_q(1);
    wr(A_CTRL, ctl(4'h1, 2'b11, 1'b1));
    wait_q(6);
    rd_chk("start kept", A_CTRL, ctl(4'h1, 2'b11, 1'b1) | 32'h100);
    wr(A_CTRL, ctl(4'h1, 2'b11, 1'b0));
    wait_idle(lat[0]);
    check("scan rounds", q_pack(), 32'h2101010);
    // fixed continuous, then mode change to single mid-conversion
    seen_q.delete();
    wr(A_CTRL, ctl(4'h6, 2'b01, 1'b1));
    wait_q(2);
    wr(A_CTRL, ctl(4'h6, 2'b00, 1'b1));
    wait_idle(lat[0]);
    check("mode change", q_pack(), 32'h66);
    rd_chk("single stop", A_CTRL, ctl(4'h6, 2'b00, 1'b0));
    // software stop of fixed continuous
    seen_q.delete();
    wr(A_CTRL, ctl(4'h6, 2'b01, 1'b1));
    wait_q(1);
    wr(A_CTRL, ctl(4'h6, 2'b01, 1'b0));
    wait_idle(lat[0]);
    check("fixed stop", q_pack(), 32'h6);
    // restart by clear then set, with a new channel
    seen_q.delete();
    wr(A_CTRL, ctl(4'h4, 2'b00, 1'b1));
    wait_q(1);
    wr(A_CTRL, ctl(4'h4, 2'b00, 1'b0));
    wr(A_CTRL, ctl(4'h7, 2'b00, 1'b1));
    wait_idle(lat[0]);
    check("restart", q_pack(), 32'h47);
    rd_chk("restart result", A_RES, 32'h71eb);
    rd_chk("injected kept", A_INJ, 32'h5a3c);
    wrap_up();
  end
endmodule : adc_conversion_sequencer_test
